// ==== rtl/tone_regs_pkg.sv ====
// package: register map, reset values, field layouts and carriers for the decoder control bank
package tone_regs_pkg;

    // register offsets on the byte-wide control bus
    localparam logic [7:0] OFS_CLK_MODE    = 8'h63;
    localparam logic [7:0] OFS_PLL_FRAC_LO = 8'h64;
    localparam logic [7:0] OFS_PLL_FRAC_HI = 8'h65;
    localparam logic [7:0] OFS_FRAMES_LO   = 8'h67;
    localparam logic [7:0] OFS_FRAMES_MID  = 8'h68;
    localparam logic [7:0] OFS_FRAMES_HI   = 8'h69;
    localparam logic [7:0] OFS_MEAN_RATE   = 8'h6a;
    localparam logic [7:0] OFS_FW_VERSION  = 8'h71;
    localparam logic [7:0] OFS_DECODE_GO   = 8'h72;
    localparam logic [7:0] OFS_HS_CORN_LO  = 8'h77;
    localparam logic [7:0] OFS_HS_CORN_HI  = 8'h78;
    localparam logic [7:0] OFS_LS_CORN_LO  = 8'h79;
    localparam logic [7:0] OFS_LS_CORN_HI  = 8'h7a;
    localparam logic [7:0] OFS_HS_GAIN     = 8'h7b;
    localparam logic [7:0] OFS_OUT_DIV     = 8'h61;

    // reset values
    localparam logic [7:0] RST_ZERO        = 8'h00;
    localparam logic [7:0] RST_FRAC_LO     = 8'h46;
    localparam logic [7:0] RST_FRAC_HI     = 8'h5b;
    localparam logic [4:0] RST_OUT_DIV     = 5'h07;
    // arbitrary version value, not tied to any product
    localparam logic [7:0] FW_VERSION_CODE = 8'h10;

    // field positions and widths
    localparam int MODE_BIT       = 0;   // fixed-frequency mode flag
    localparam int GO_BIT         = 0;   // run flag
    localparam int OUT_DIV_W      = 5;   // output divider field width
    localparam int FRAC_W         = 16;  // pll fraction width
    localparam int FRAME_W        = 24;  // frame counter width
    localparam int FRAC_HI_WEIGHT = 256; // weight of the fraction high byte
    localparam int FRAC_FULL      = 65536;

    // tracking-mode ratio codes and the default oversampling clock
    typedef enum logic [1:0] {RATIO_256, RATIO_384, RATIO_512} osc_ratio_t;
    localparam int RATIO_256_MULT = 256;
    localparam int RATIO_384_MULT = 384;
    localparam int RATIO_512_MULT = 512;
    localparam int OSC_DEFAULT_KHZ = 12288;  // 12.288 MHz

    // gain limits in 1.5 dB steps (+-18 dB)
    localparam logic signed [7:0] GAIN_MAX = 8'sh0c;
    localparam logic signed [7:0] GAIN_MIN = -8'sh0c;

    // register bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

    // pll settings handed to the clock generator
    typedef struct packed {
        logic        fixed_mode;
        osc_ratio_t  ratio;
        logic [15:0] fraction;
        logic [4:0]  out_div;
    } pll_cfg_t;

    // tone settings handed to the equaliser
    typedef struct packed {
        logic [15:0]       treble_hz;
        logic [15:0]       bass_hz;
        logic signed [7:0] treble_steps;
    } tone_cfg_t;

endpackage

// ==== rtl/frame_tally.sv ====
// 24-bit decoded-frame counter with soft clear
`timescale 1ns/1ps
module frame_tally
    import tone_regs_pkg::*;
(
    input  wire logic               ref_clk,    // system clock
    input  wire logic               nrst,       // async reset, low
    input  wire logic               ce,         // clock enable
    input  wire logic               soft_clr,   // software reset pulse
    input  wire logic               frame_done, // one pulse per decoded frame
    output logic [FRAME_W-1:0]      count       // running total
);
    logic [FRAME_W-1:0] count_r;  // held total
    logic [FRAME_W-1:0] count_nxt;

    // clear wins: a frame in the reset cycle belongs to the old stream
    always_comb begin
        count_nxt = count_r;
        if (soft_clr) begin
            count_nxt = '0;
        end else if (frame_done) begin
            count_nxt = count_r + {{(FRAME_W-1){1'b0}}, 1'b1};
        end
    end

    // register stage
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count_r <= '0;
        end else if (ce) begin
            count_r <= count_nxt;
        end
    end

    assign count = count_r;
endmodule

// ==== rtl/rate_average.sv ====
// mean stream rate in kbit/s, rounded, from per-frame measurements
`timescale 1ns/1ps
module rate_average
    import tone_regs_pkg::*;
(
    input  wire logic        ref_clk,     // system clock
    input  wire logic        nrst,        // async reset, low
    input  wire logic        ce,          // clock enable
    input  wire logic        soft_clr,    // software reset pulse
    input  wire logic        frame_done,  // sample strobe
    input  wire logic [15:0] frame_bps,   // frame rate in bit/s / 8 (units of 8 bit/s)
    output logic [7:0]       mean_kbps    // rounded average
);
    logic [15:0] acc_r;   // running mean, units of 8 bit/s
    logic [15:0] acc_nxt;
    logic [7:0]  out_r;   // rounded result
    logic [7:0]  out_nxt;
    logic [16:0] sum;     // mean plus half a kbit for rounding
    logic [16:0] blend;   // first-order averager input

    // simple 1/2 weighting keeps the averager cheap; it settles in a few frames
    always_comb begin
        blend   = {1'b0, acc_r} + {1'b0, frame_bps};
        acc_nxt = acc_r;
        out_nxt = out_r;
        sum     = {1'b0, acc_r} + 17'd62;   // 62.5 units of 8 bit/s is half a kbit
        if (soft_clr) begin
            acc_nxt = '0;
            out_nxt = '0;
        end else if (frame_done) begin
            acc_nxt = blend[16:1];
            out_nxt = 8'(sum / 17'd125);    // 125 units = 1 kbit/s
        end
    end

    // register stage
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            acc_r <= '0;
            out_r <= '0;
        end else if (ce) begin
            acc_r <= acc_nxt;
            out_r <= out_nxt;
        end
    end

    assign mean_kbps = out_r;
endmodule

// ==== rtl/decoder_clock_tone_status_regs.sv ====
// control and status register bank: clock mode, pll fraction, frame count, tone settings
// Operation
// - fixed mode holds user oscillator frequency
// - tracking mode: 512/384/256 times rate, default 256; no register writes the ratio, so it stays at 256
// - tracking mode default clock 12.288 MHz
// - fraction is high times 256 plus low
// - clock = mclk/(N+1)*(M+1+frac/65536)/(X+1)
// - fraction undefined; loaded at stream sync
// - fraction serves 48/24/12/32/16/8 kHz family; pll_cfg_apply marks it valid for the 48 kHz family only
// - 24-bit read-only decoded-frame counter
// - frame counter clears on both resets
// - mean bitrate byte, 1 kbit/s resolution
// - firmware version readable at 0x71
// - run bit set leaves idle, decodes
// - treble corner 16-bit hertz value
// - bass corner 16-bit hertz value
// - treble gain signed 1.5 dB steps, +-18
// - output divider value plus one
`timescale 1ns/1ps
module decoder_clock_tone_status_regs
    import tone_regs_pkg::*;
(
    input  wire logic        ref_clk,        // 125 MHz system clock
    input  wire logic        nrst,           // async reset, low
    input  wire logic        ce,             // clock enable, freezes all state
    input  wire logic        soft_reset,     // software reset pulse
    input  wire bus_req_t    bus_req,        // control bus request
    output logic [7:0]       bus_rdata,      // read data, registered
    output logic             bus_rvalid,     // read data valid pulse
    input  wire logic        stream_sync,    // pulse: stream sync achieved
    input  wire logic [15:0] sync_fraction,  // fraction found at sync
    input  wire logic        rate_family_48, // stream rate in 48 kHz family
    input  wire logic        frame_done,     // pulse per decoded frame
    input  wire logic [15:0] frame_bps,      // frame bitrate, units of 8 bit/s
    output pll_cfg_t         pll_cfg,        // clock generator settings
    output logic             pll_cfg_apply,  // fraction valid for current family
    output logic [15:0]      osc_khz,        // oversampling clock target, kHz
    output tone_cfg_t        tone_cfg,       // equaliser settings
    output logic             decode_run      // decoder leaves idle
);
    // control state
    logic        mode_r, mode_nxt;          // fixed-frequency flag
    logic [1:0]  ratio_r, ratio_nxt;        // tracking ratio code
    logic [7:0]  frac_lo_r, frac_lo_nxt;    // fraction low byte
    logic [7:0]  frac_hi_r, frac_hi_nxt;    // fraction high byte
    logic [4:0]  div_r, div_nxt;            // output divider
    logic        go_r, go_nxt;              // run flag
    logic [7:0]  tf_lo_r, tf_lo_nxt;        // treble corner low
    logic [7:0]  tf_hi_r, tf_hi_nxt;        // treble corner high
    logic [7:0]  bf_lo_r, bf_lo_nxt;        // bass corner low
    logic [7:0]  bf_hi_r, bf_hi_nxt;        // bass corner high
    logic [7:0]  gain_r, gain_nxt;          // treble gain steps
    logic [15:0] fix_khz_r, fix_khz_nxt;    // frequency latched for fixed mode
    logic [7:0]  rdata_r, rdata_nxt;        // read data
    logic        rvalid_r, rvalid_nxt;      // read strobe

    // status from the leaves, and values derived locally
    logic [FRAME_W-1:0] frames;             // decoded frame total
    logic [7:0]         mean_kbps;          // rounded mean rate
    logic [15:0]        track_khz;          // rate-tracking frequency
    logic [15:0]        fraction;           // concatenated fraction
    logic signed [7:0]  gain_clamped;       // gain limited to +-18 dB

    // decoded frame counter
    frame_tally u_tally (
        .ref_clk    (ref_clk),
        .nrst       (nrst),
        .ce         (ce),
        .soft_clr   (soft_reset),
        .frame_done (frame_done),
        .count      (frames)
    );

    // mean bitrate
    rate_average u_rate (
        .ref_clk    (ref_clk),
        .nrst       (nrst),
        .ce         (ce),
        .soft_clr   (soft_reset),
        .frame_done (frame_done),
        .frame_bps  (frame_bps),
        .mean_kbps  (mean_kbps)
    );

    // fraction weighs high byte by 256
    assign fraction = {frac_hi_r, frac_lo_r};

    // tracking frequency relative to the 12.288 MHz default at 256x
    always_comb begin
        unique case (osc_ratio_t'(ratio_r))
            RATIO_512: track_khz = 16'(OSC_DEFAULT_KHZ * RATIO_512_MULT / RATIO_256_MULT);
            RATIO_384: track_khz = 16'(OSC_DEFAULT_KHZ * RATIO_384_MULT / RATIO_256_MULT);
            RATIO_256: track_khz = 16'(OSC_DEFAULT_KHZ);
            default:   track_khz = 16'(OSC_DEFAULT_KHZ);          // code 3 is illegal
        endcase
    end

    // gain clamp to the legal range
    always_comb begin
        if ($signed(gain_r) > GAIN_MAX) begin
            gain_clamped = GAIN_MAX;
        end else if ($signed(gain_r) < GAIN_MIN) begin
            gain_clamped = GAIN_MIN;
        end else begin
            gain_clamped = $signed(gain_r);
        end
    end

    // next-state for all control registers and the read port
    always_comb begin
        mode_nxt    = mode_r;
        ratio_nxt   = ratio_r;
        frac_lo_nxt = frac_lo_r;
        frac_hi_nxt = frac_hi_r;
        div_nxt     = div_r;
        go_nxt      = go_r;
        tf_lo_nxt   = tf_lo_r;
        tf_hi_nxt   = tf_hi_r;
        bf_lo_nxt   = bf_lo_r;
        bf_hi_nxt   = bf_hi_r;
        gain_nxt    = gain_r;
        fix_khz_nxt = fix_khz_r;
        rdata_nxt   = rdata_r;
        rvalid_nxt  = 1'b0;
        // fixed mode freezes the frequency in force when it was entered
        if (!mode_r) begin
            fix_khz_nxt = track_khz;
        end
        // core loads the operational fraction at sync; a host write below wins
        if (stream_sync) begin
            frac_lo_nxt = sync_fraction[7:0];
            frac_hi_nxt = sync_fraction[15:8];
        end
        if (bus_req.wr) begin
            // only implemented bits take the write
            unique case (bus_req.addr)
                OFS_CLK_MODE:    mode_nxt    = bus_req.wdata[MODE_BIT];
                OFS_PLL_FRAC_LO: frac_lo_nxt = bus_req.wdata;
                OFS_PLL_FRAC_HI: frac_hi_nxt = bus_req.wdata;
                OFS_OUT_DIV:     div_nxt     = bus_req.wdata[OUT_DIV_W-1:0];
                OFS_DECODE_GO:   go_nxt      = bus_req.wdata[GO_BIT];
                OFS_HS_CORN_LO:  tf_lo_nxt   = bus_req.wdata;
                OFS_HS_CORN_HI:  tf_hi_nxt   = bus_req.wdata;
                OFS_LS_CORN_LO:  bf_lo_nxt   = bus_req.wdata;
                OFS_LS_CORN_HI:  bf_hi_nxt   = bus_req.wdata;
                OFS_HS_GAIN:     gain_nxt    = bus_req.wdata;
                default:         ratio_nxt   = ratio_r;  // read-only or unmapped
            endcase
        end
        if (bus_req.rd) begin
            rvalid_nxt = 1'b1;
            unique case (bus_req.addr)
                OFS_CLK_MODE:    rdata_nxt = {7'h00, mode_r};
                OFS_PLL_FRAC_LO: rdata_nxt = frac_lo_r;
                OFS_PLL_FRAC_HI: rdata_nxt = frac_hi_r;
                OFS_OUT_DIV:     rdata_nxt = {3'h0, div_r};
                OFS_FRAMES_LO:   rdata_nxt = frames[7:0];
                OFS_FRAMES_MID:  rdata_nxt = frames[15:8];
                OFS_FRAMES_HI:   rdata_nxt = frames[23:16];
                OFS_MEAN_RATE:   rdata_nxt = mean_kbps;
                OFS_FW_VERSION:  rdata_nxt = FW_VERSION_CODE;
                OFS_DECODE_GO:   rdata_nxt = {7'h00, go_r};
                OFS_HS_CORN_LO:  rdata_nxt = tf_lo_r;
                OFS_HS_CORN_HI:  rdata_nxt = tf_hi_r;
                OFS_LS_CORN_LO:  rdata_nxt = bf_lo_r;
                OFS_LS_CORN_HI:  rdata_nxt = bf_hi_r;
                OFS_HS_GAIN:     rdata_nxt = gain_r;
                default:         rdata_nxt = 8'h00;                   // unmapped
            endcase
        end
        // software reset returns every control byte to its reset value
        if (soft_reset) begin
            mode_nxt    = 1'b0;
            ratio_nxt   = 2'(RATIO_256);
            frac_lo_nxt = RST_FRAC_LO;
            frac_hi_nxt = RST_FRAC_HI;
            div_nxt     = RST_OUT_DIV;
            go_nxt      = 1'b0;
            tf_lo_nxt   = RST_ZERO;
            tf_hi_nxt   = RST_ZERO;
            bf_lo_nxt   = RST_ZERO;
            bf_hi_nxt   = RST_ZERO;
            gain_nxt    = RST_ZERO;
        end
    end

    // register stage; ce low freezes everything
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mode_r    <= 1'b0;
            ratio_r   <= 2'(RATIO_256);
            frac_lo_r <= RST_FRAC_LO;   // no defined value; any constant is legal
            frac_hi_r <= RST_FRAC_HI;
            div_r     <= RST_OUT_DIV;
            go_r      <= 1'b0;
            tf_lo_r   <= RST_ZERO;
            tf_hi_r   <= RST_ZERO;
            bf_lo_r   <= RST_ZERO;
            bf_hi_r   <= RST_ZERO;
            gain_r    <= RST_ZERO;
            fix_khz_r <= 16'(OSC_DEFAULT_KHZ);
            rdata_r   <= RST_ZERO;
            rvalid_r  <= 1'b0;
        end else if (ce) begin
            mode_r    <= mode_nxt;
            ratio_r   <= ratio_nxt;
            frac_lo_r <= frac_lo_nxt;
            frac_hi_r <= frac_hi_nxt;
            div_r     <= div_nxt;
            go_r      <= go_nxt;
            tf_lo_r   <= tf_lo_nxt;
            tf_hi_r   <= tf_hi_nxt;
            bf_lo_r   <= bf_lo_nxt;
            bf_hi_r   <= bf_hi_nxt;
            gain_r    <= gain_nxt;
            fix_khz_r <= fix_khz_nxt;
            rdata_r   <= rdata_nxt;
            rvalid_r  <= rvalid_nxt;
        end
    end

    // clock target: fixed mode ignores rate changes, tracking follows the ratio
    assign osc_khz = mode_r ? fix_khz_r : track_khz;

    // settings for the clock generator, which computes
    // mclk/(N+1) * (M+1 + fraction/65536) / (out_div+1)
    assign pll_cfg.fixed_mode = mode_r;
    assign pll_cfg.ratio      = osc_ratio_t'(ratio_r);
    assign pll_cfg.fraction   = fraction;
    assign pll_cfg.out_div    = div_r;
    // the fraction only applies to the 48 kHz family
    assign pll_cfg_apply      = rate_family_48;

    // tone settings
    assign tone_cfg.treble_hz    = {tf_hi_r, tf_lo_r};
    assign tone_cfg.bass_hz      = {bf_hi_r, bf_lo_r};
    assign tone_cfg.treble_steps = gain_clamped;

    assign decode_run = go_r;
    assign bus_rdata  = rdata_r;
    assign bus_rvalid = rvalid_r;
endmodule

// ==== tb/tone_regs_checker.sv ====
// assertion checker for the decoder control register bank
`timescale 1ns/1ps
module tone_regs_checker
    import tone_regs_pkg::*;
(
    input wire logic        ref_clk,        // system clock
    input wire logic        nrst,           // async reset, low
    input wire logic        ce,             // clock enable
    input wire logic        soft_reset,     // software reset pulse
    input wire bus_req_t    bus_req,        // control bus request
    input wire logic [7:0]  bus_rdata,      // read data
    input wire logic        bus_rvalid,     // read data valid
    input wire logic        stream_sync,    // sync achieved pulse
    input wire logic [15:0] sync_fraction,  // fraction found at sync
    input wire logic        rate_family_48, // rate family flag
    input wire logic        frame_done,     // frame pulse
    input wire logic [15:0] frame_bps,      // frame bitrate
    input wire pll_cfg_t    pll_cfg,        // pll settings
    input wire logic        pll_cfg_apply,  // fraction applies
    input wire logic [15:0] osc_khz,        // clock target, kHz
    input wire tone_cfg_t   tone_cfg,       // tone settings
    input wire logic        decode_run      // run flag
);
    // single domain, so clock and reset are stated once
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic       wr_ok;   // write taken, soft reset not overriding it
    logic       rd_tk;   // read taken
    logic       wd0;     // bit 0 of write data
    logic [7:0] wd;      // write data
    logic [7:0] ad;      // request address
    assign wr_ok = ce && bus_req.wr && !soft_reset;
    assign rd_tk = ce && bus_req.rd;
    assign wd0   = bus_req.wdata[0];
    assign wd    = bus_req.wdata;
    assign ad    = bus_req.addr;

    rv_after_rd_a: assert property (rd_tk |=> bus_rvalid)
        else $error("read valid missing after a read");
    rv_needs_rd_a: assert property (bus_rvalid |-> $past(rd_tk))
        else $error("read valid without a read");
    run_bit_a: assert property (
        wr_ok && ad == 8'h72 |=> decode_run == $past(wd0))
        else $error("run flag does not follow write");
    mode_bit_a: assert property (
        wr_ok && ad == 8'h63 |=> pll_cfg.fixed_mode == $past(wd0))
        else $error("clock mode does not follow write");
    frac_low_a: assert property (
        wr_ok && ad == 8'h64 |=> pll_cfg.fraction[7:0] == $past(wd))
        else $error("fraction low byte wrong");
    out_div_a: assert property (
        wr_ok && ad == 8'h61 |=> {3'h0, pll_cfg.out_div} == ($past(wd) & 8'h1f))
        else $error("output divider wrong");
    treble_hi_a: assert property (
        wr_ok && ad == 8'h78 |=> tone_cfg.treble_hz[15:8] == $past(wd))
        else $error("treble corner high byte wrong");
    // host write to the fraction wins, so only clean sync cycles are judged
    sync_load_a: assert property (ce && stream_sync && !soft_reset
        && !(bus_req.wr && (ad == 8'h64 || ad == 8'h65))
        |=> pll_cfg.fraction == $past(sync_fraction))
        else $error("fraction not loaded at sync");
    family_apply_a: assert property (pll_cfg_apply == rate_family_48)
        else $error("fraction apply does not track family");
    track_clock_a: assert property (!pll_cfg.fixed_mode |-> osc_khz == 16'h3000
        && pll_cfg.ratio == RATIO_256)
        else $error("tracking clock not at default");
    gain_range_a: assert property (tone_cfg.treble_steps <= GAIN_MAX
        && tone_cfg.treble_steps >= GAIN_MIN)
        else $error("treble steps outside range");
    mode_unused_a: assert property (
        bus_rvalid && $past(ad) == 8'h63 |-> bus_rdata[7:1] == 7'h00)
        else $error("unused mode bits read nonzero");
endmodule

bind decoder_clock_tone_status_regs tone_regs_checker chk (
    .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .soft_reset(soft_reset), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .stream_sync(stream_sync),
    .sync_fraction(sync_fraction), .rate_family_48(rate_family_48), .frame_done(frame_done),
    .frame_bps(frame_bps), .pll_cfg(pll_cfg), .pll_cfg_apply(pll_cfg_apply),
    .osc_khz(osc_khz), .tone_cfg(tone_cfg), .decode_run(decode_run));

// ==== tb/tb.sv ====
// self-checking bench for the decoder control register bank
`timescale 1ns/1ps
module tb
    import tone_regs_pkg::*;
;
    logic        ref_clk;        // 125 MHz clock
    logic        nrst;           // async reset, low
    logic        ce;             // clock enable
    logic        soft_reset;     // software reset pulse
    bus_req_t    bus_req;        // control bus request
    logic [7:0]  bus_rdata;      // read data
    logic        bus_rvalid;     // read valid
    logic        stream_sync;    // sync pulse
    logic [15:0] sync_fraction;  // fraction at sync
    logic        rate_family_48; // rate family flag
    logic        frame_done;     // frame pulse
    logic [15:0] frame_bps;      // frame bitrate
    pll_cfg_t    pll_cfg;        // pll settings
    logic        pll_cfg_apply;  // fraction applies
    logic [15:0] osc_khz;        // clock target
    tone_cfg_t   tone_cfg;       // tone settings
    logic        decode_run;     // run flag
    int          num_errors;     // mismatches
    int          n_compared;     // comparisons
    // writable registers: address, live bits, reset value; run byte last
    logic [7:0]  rw_a [10] = '{8'h63, 8'h64, 8'h65, 8'h61, 8'h77,
                               8'h78, 8'h79, 8'h7a, 8'h7b, 8'h72};
    logic [7:0]  rw_m [10] = '{8'h01, 8'hff, 8'hff, 8'h1f, 8'hff,
                               8'hff, 8'hff, 8'hff, 8'hff, 8'h01};
    logic [7:0]  rw_r [10] = '{8'h00, 8'h46, 8'h5b, 8'h07, 8'h00,
                               8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    // gain written and the clamped value expected on the output
    logic [7:0]  g_w  [6]  = '{8'h0c, 8'hf4, 8'h0d, 8'hf3, 8'h80, 8'h01};
    logic [7:0]  g_e  [6]  = '{8'h0c, 8'hf4, 8'h0c, 8'hf4, 8'hf4, 8'h01};

    decoder_clock_tone_status_regs uut (
        .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .soft_reset(soft_reset), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .stream_sync(stream_sync),
        .sync_fraction(sync_fraction), .rate_family_48(rate_family_48), .frame_done(frame_done),
        .frame_bps(frame_bps), .pll_cfg(pll_cfg), .pll_cfg_apply(pll_cfg_apply),
        .osc_khz(osc_khz), .tone_cfg(tone_cfg), .decode_run(decode_run));

    // free-running clock, 8 ns period
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // compare any value up to a word wide, counting every check
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // bus write; request held for exactly one taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk); #1;
        bus_req = '0;
        @(posedge ref_clk); #1;
    endtask

    // bus read; valid and data looked at in the cycle they stand
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        bus_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk); #1;
        bus_req = '0;
        chk("rvalid", 16'h0001, {15'h0, bus_rvalid});
        chk($sformatf("reg %h", a), {8'h0, e}, {8'h0, bus_rdata});
        @(posedge ref_clk); #1;
    endtask

    // one frame pulse; ce low shows that frozen state ignores it
    task automatic frame(input logic en);
        ce = en;
        frame_done = 1'b1;
        @(posedge ref_clk); #1;
        frame_done = 1'b0;
        ce = 1'b1;
        @(posedge ref_clk); #1;
    endtask

    task automatic t_reset;
        for (int i = 0; i < 10; i++) rd_chk(rw_a[i], rw_r[i]);
        for (int a = 8'h67; a <= 8'h6a; a++) rd_chk(a[7:0], 8'h00);
        rd_chk(8'h71, FW_VERSION_CODE);
        rd_chk(8'h66, 8'h00);
        chk("out_div", 16'h0007, {11'h0, pll_cfg.out_div});
        chk("run", 16'h0000, {15'h0, decode_run});
        $display("test reset values done");
    endtask

    task automatic t_rw;
        // run byte goes last, once every other control byte is set
        for (int i = 0; i < 10; i++) wr(rw_a[i], 8'hff);
        for (int i = 0; i < 10; i++) rd_chk(rw_a[i], rw_m[i]);
        chk("fraction", 16'hffff, pll_cfg.fraction);
        chk("fixed", 16'h0001, {15'h0, pll_cfg.fixed_mode});
        chk("osc_fixed", 16'h3000, osc_khz);
        chk("run", 16'h0001, {15'h0, decode_run});
        chk("out_div", 16'h001f, {11'h0, pll_cfg.out_div});
        // read-only bytes must shrug off writes
        for (int a = 8'h67; a <= 8'h6a; a++) wr(a[7:0], 8'hff);
        for (int a = 8'h67; a <= 8'h6a; a++) rd_chk(a[7:0], 8'h00);
        wr(8'h63, 8'h00);
        chk("osc_khz", 16'h3000, osc_khz);
        $display("test register access done");
    endtask

    task automatic t_tone;
        wr(8'h77, 8'hb8);
        wr(8'h78, 8'h0b);
        wr(8'h79, 8'hc8);
        wr(8'h7a, 8'h00);
        chk("treble_hz", 16'h0bb8, tone_cfg.treble_hz);
        chk("bass_hz", 16'h00c8, tone_cfg.bass_hz);
        for (int i = 0; i < 6; i++) begin
            wr(8'h7b, g_w[i]);
            chk("steps", {8'h0, g_e[i]}, {8'h0, tone_cfg.treble_steps});
            rd_chk(8'h7b, g_w[i]);
        end
        $display("test tone settings done");
    endtask

    task automatic t_sync;
        sync_fraction = 16'h1234;
        stream_sync = 1'b1;
        @(posedge ref_clk); #1;
        stream_sync = 1'b0;
        chk("fraction", 16'h1234, pll_cfg.fraction);
        // let an edge pass so the sync strobe really drops between pulses
        @(posedge ref_clk); #1;
        // host write and sync in one cycle: the write keeps its byte
        sync_fraction = 16'h5678;
        stream_sync = 1'b1;
        bus_req = '{wr: 1'b1, rd: 1'b0, addr: 8'h64, wdata: 8'haa};
        @(posedge ref_clk); #1;
        stream_sync = 1'b0;
        bus_req = '0;
        chk("frac_lo", 16'h00aa, {8'h0, pll_cfg.fraction[7:0]});
        for (int f = 0; f < 2; f++) begin
            rate_family_48 = f[0];
            @(posedge ref_clk); #1;
            chk("apply", {15'h0, f[0]}, {15'h0, pll_cfg_apply});
        end
        $display("test stream sync done");
    endtask

    task automatic t_frames;
        frame_bps = 16'd16000;
        for (int i = 0; i < 260; i++) frame(1'b1);
        frame(1'b0);
        rd_chk(8'h67, 8'h04);
        rd_chk(8'h68, 8'h01);
        rd_chk(8'h69, 8'h00);
        rd_chk(8'h6a, 8'h80);
        soft_reset = 1'b1;
        @(posedge ref_clk); #1;
        soft_reset = 1'b0;
        for (int a = 8'h67; a <= 8'h6a; a++) rd_chk(a[7:0], 8'h00);
        for (int i = 0; i < 10; i++) rd_chk(rw_a[i], rw_r[i]);
        $display("test frame count done");
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // hang guard, far beyond the roughly 700 cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        give_verdict();
    end

    initial begin
        {nrst, soft_reset, stream_sync, rate_family_48, frame_done} = '0;
        ce = 1'b1;
        bus_req = '0;
        sync_fraction = 16'h0000;
        frame_bps = 16'h0000;
        num_errors = 0;
        n_compared = 0;
        repeat (20) @(posedge ref_clk);
        #1 nrst = 1'b1;
        t_reset();
        t_rw();
        t_tone();
        t_sync();
        t_frames();
        give_verdict();
    end
endmodule
